/* File: shared/flag_bank_pkg.sv */
/*
 Holds the constants and carrier types of the supply and reset flag bank.
 Assumes a 50 MHz core clock; imported by no one, used by scoped names.
*/
package flag_bank_pkg;
    localparam int CLK_HZ = 50_000_000;
    localparam int SHORT_FILTER_US = 100;
    localparam int LONG_FILTER_MS = 100;
    localparam int SHORT_FILTER_CYC = SHORT_FILTER_US * (CLK_HZ / 1_000_000);
    localparam int LONG_FILTER_CYC = LONG_FILTER_MS * (CLK_HZ / 1_000);
    localparam int MULTI_RESET_LIMIT = 8;
    localparam logic [3:0] RESET_CNT_INIT = 4'h0;
    localparam logic [12:0] FLAGS_INIT = 13'h0000;
    localparam int SYNC_STAGES = 3;

    // raw conditions from the analogue side and the serial request
    typedef struct packed {
        logic int_request;
        logic rst_high;
        logic dbg_mismatch;
        logic temp_prewarn;
        logic main_uv;
        logic main_ov;
        logic aux_ov;
        logic rst_low;
    } cond_t;

    // latched flags as seen by the serial read path
    typedef struct packed {
        logic int_request;
        logic rst_high;
        logic dbg_mismatch;
        logic temp_prewarn;
        logic main_uv;
        logic main_ov;
        logic aux_ov;
        logic main_uv_long;
        logic main_low;
        logic rst_low_long;
        logic multi_reset;
        logic wd_fail;
        logic spare;
    } flags_t;

    // one-cycle read strobes, one per flag group
    typedef struct packed {
        logic int_request;
        logic rst_high;
        logic dbg_mismatch;
        logic temp_prewarn;
        logic main_uv;
        logic main_ov;
        logic aux_ov;
        logic main_uv_long;
        logic main_low;
        logic rst_low_long;
        logic multi_reset;
        logic wd_fail;
    } rd_t;
endpackage

/* File: rtl/sticky_flag.sv */
/*
 Holds one read-to-clear flag with optional persistence filter.
 Assumes a synchronised cause and a one-cycle read strobe on i_clk.
*/
`timescale 1ns/1ps
module sticky_flag #(
    parameter int FILTER_CYC = 1,
    parameter bit NEED_RECOVER = 1'b1
) (
    input wire logic i_clk, // core clock
    input wire logic i_arst_n, // async reset, active low
    input wire logic i_cause, // synchronised cause level
    input wire logic i_rd, // clearing read strobe
    output logic o_flag // latched flag
);
    // one spare count so that a zero filter still has a counter bit
    localparam int CW = $clog2(FILTER_CYC + 2);
    logic [CW-1:0] cnt_q;
    logic [CW-1:0] cnt_d;
    logic flag_q;
    logic flag_d;
    logic hit;

    always_comb begin
        cnt_d = cnt_q;
        if (!i_cause) begin
            cnt_d = '0;
        end else if (cnt_q != CW'(FILTER_CYC)) begin
            cnt_d = cnt_q + CW'(1);
        end
        hit = i_cause && (cnt_q == CW'(FILTER_CYC));
        flag_d = flag_q;
        if (i_rd && !(NEED_RECOVER && i_cause)) begin
            flag_d = 1'b0;
        end
        // set wins over the clearing read
        if (hit) begin
            flag_d = 1'b1;
        end
    end

    always_ff @(posedge i_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            cnt_q <= '0;
            flag_q <= 1'b0;
        end else begin
            cnt_q <= cnt_d;
            flag_q <= flag_d;
        end
    end

    assign o_flag = flag_q;
endmodule

/* File: rtl/supply_reset_flag_bank.sv */
/*
 Holds the supply and reset flag bank: latched supply, reset-pin and
 watchdog flags, plus static variant and revision fields.
 Assumes analogue comparators deliver asynchronous levels, watchdog and
 request events arrive as one-cycle pulses on i_clk, and the serial
 block pulses a read strobe per flag when the flag is read.
*/
`timescale 1ns/1ps
// Operation
// - set on serial interrupt request, clear on read
// - reset pin shorted high, clear on read
// - debug resistor mismatch, clear on match and read
// - thermal prewarning, clear below threshold and read
// - undervoltage over 100 us, clear recovered and read
// - main overvoltage over 100 us, may drop io1
// - aux overvoltage over 100 us, may drop io1
// - undervoltage over 100 ms, clear recovered and read
// - main low flag, clear on read only
// - static bit: 0 for 3.3 V, 1 for 5.0 V
// - two-bit read-only family member code
// - five-bit read-only silicon revision, bits 4..0
// - reset low over 100 ms, clear ended and read
// - more than 8 watchdog resets set flag
// - watchdog refresh failure, clear on read
module supply_reset_flag_bank #(
    parameter int SHORT_CYC = flag_bank_pkg::SHORT_FILTER_CYC,
    parameter int LONG_CYC = flag_bank_pkg::LONG_FILTER_CYC,
    parameter bit VARIANT_5V = 1'b1,
    parameter logic [1:0] FAMILY_CODE = 2'h3, // arbitrary value
    parameter logic [4:0] REVISION_CODE = 5'h01 // arbitrary value
) (
    input wire logic i_clk, // 50 MHz core clock
    input wire logic i_arst_n, // power-on reset, active low
    input wire logic i_int_req, // serial interrupt request pulse
    input wire logic i_rst_high_fault, // reset pin shorted high (async)
    input wire logic i_dbg_sensed_ok, // debug_select_pin matches config
    input wire logic i_temp_over, // main thermal above prewarn (async)
    input wire logic i_main_below_uv, // below main_undervoltage_threshold
    input wire logic i_main_above_ov, // main above nominal+0.6 V (async)
    input wire logic i_aux_above_ov, // aux_regulator_output overvoltage
    input wire logic i_rst_pin_low, // reset pin sensed low (async)
    input wire logic i_wd_reset, // reset pulse from watchdog fault
    input wire logic i_wd_good, // correct watchdog refresh pulse
    input wire logic i_wd_fail, // wrong or missing refresh pulse
    input wire logic i_io1_ov_off_en, // config: drop io1 on overvoltage
    input flag_bank_pkg::rd_t i_rd, // clearing read strobes
    output flag_bank_pkg::flags_t o_flags, // latched flags
    output logic o_vdd_5v, // variant bit
    output logic [1:0] o_family, // family member code
    output logic [4:0] o_revision, // silicon revision code
    output logic o_io1_off // request to switch wake io1 off
);
    // ------------------------------------------------------------
    // pin synchronisers
    // ------------------------------------------------------------
    localparam int NA = 7;
    logic [NA-1:0] raw_async;
    logic [NA-1:0] s1_q;
    logic [NA-1:0] s2_q;
    logic [NA-1:0] s3_q;
    logic [NA-1:0] lvl_q;
    logic [NA-1:0] lvl_d;
    flag_bank_pkg::cond_t cond;

    assign raw_async = {i_rst_high_fault, ~i_dbg_sensed_ok, i_temp_over,
                        i_main_below_uv, i_main_above_ov, i_aux_above_ov,
                        i_rst_pin_low};

    // a change counts once stages two and three agree
    always_comb begin
        lvl_d = lvl_q;
        for (int i = 0; i < NA; i++) begin
            if (s2_q[i] == s3_q[i]) begin
                lvl_d[i] = s3_q[i];
            end
        end
    end

    always_ff @(posedge i_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            s1_q <= '0;
            s2_q <= '0;
            s3_q <= '0;
            lvl_q <= '0;
        end else begin
            s1_q <= raw_async;
            s2_q <= s1_q;
            s3_q <= s2_q;
            lvl_q <= lvl_d;
        end
    end

    always_comb begin
        cond.int_request = i_int_req;
        {cond.rst_high, cond.dbg_mismatch, cond.temp_prewarn, cond.main_uv,
         cond.main_ov, cond.aux_ov, cond.rst_low} = lvl_q;
    end

    // ------------------------------------------------------------
    // latched flags
    // ------------------------------------------------------------
    logic f_int, f_rsth, f_dbg, f_temp, f_uv, f_ov, f_aux;
    logic f_uvl, f_low, f_rstl;

    // a one-cycle request pulse must set the flag on its only sample
    sticky_flag #(.FILTER_CYC(0), .NEED_RECOVER(1'b0)) u_int (
        .i_clk(i_clk), .i_arst_n(i_arst_n), .i_cause(cond.int_request),
        .i_rd(i_rd.int_request), .o_flag(f_int));
    sticky_flag #(.FILTER_CYC(1), .NEED_RECOVER(1'b0)) u_rsth (
        .i_clk(i_clk), .i_arst_n(i_arst_n), .i_cause(cond.rst_high),
        .i_rd(i_rd.rst_high), .o_flag(f_rsth));
    sticky_flag #(.FILTER_CYC(1), .NEED_RECOVER(1'b1)) u_dbg (
        .i_clk(i_clk), .i_arst_n(i_arst_n), .i_cause(cond.dbg_mismatch),
        .i_rd(i_rd.dbg_mismatch), .o_flag(f_dbg));
    sticky_flag #(.FILTER_CYC(1), .NEED_RECOVER(1'b1)) u_temp (
        .i_clk(i_clk), .i_arst_n(i_arst_n), .i_cause(cond.temp_prewarn),
        .i_rd(i_rd.temp_prewarn), .o_flag(f_temp));
    sticky_flag #(.FILTER_CYC(SHORT_CYC), .NEED_RECOVER(1'b1)) u_uv (
        .i_clk(i_clk), .i_arst_n(i_arst_n), .i_cause(cond.main_uv),
        .i_rd(i_rd.main_uv), .o_flag(f_uv));
    sticky_flag #(.FILTER_CYC(SHORT_CYC), .NEED_RECOVER(1'b1)) u_ov (
        .i_clk(i_clk), .i_arst_n(i_arst_n), .i_cause(cond.main_ov),
        .i_rd(i_rd.main_ov), .o_flag(f_ov));
    sticky_flag #(.FILTER_CYC(SHORT_CYC), .NEED_RECOVER(1'b1)) u_aux (
        .i_clk(i_clk), .i_arst_n(i_arst_n), .i_cause(cond.aux_ov),
        .i_rd(i_rd.aux_ov), .o_flag(f_aux));
    sticky_flag #(.FILTER_CYC(LONG_CYC), .NEED_RECOVER(1'b1)) u_uvl (
        .i_clk(i_clk), .i_arst_n(i_arst_n), .i_cause(cond.main_uv),
        .i_rd(i_rd.main_uv_long), .o_flag(f_uvl));
    sticky_flag #(.FILTER_CYC(1), .NEED_RECOVER(1'b0)) u_low (
        .i_clk(i_clk), .i_arst_n(i_arst_n), .i_cause(cond.main_uv),
        .i_rd(i_rd.main_low), .o_flag(f_low));
    sticky_flag #(.FILTER_CYC(LONG_CYC), .NEED_RECOVER(1'b1)) u_rstl (
        .i_clk(i_clk), .i_arst_n(i_arst_n), .i_cause(cond.rst_low),
        .i_rd(i_rd.rst_low_long), .o_flag(f_rstl));

    // ------------------------------------------------------------
    // watchdog reset counting
    // ------------------------------------------------------------
    logic [3:0] rst_cnt_q;
    logic [3:0] rst_cnt_d;
    logic multi_q;
    logic multi_d;
    logic wdf_q;
    logic wdf_d;
    logic io1_off_q;
    logic io1_off_d;

    always_comb begin
        rst_cnt_d = rst_cnt_q;
        if (i_wd_good) begin
            rst_cnt_d = flag_bank_pkg::RESET_CNT_INIT;
        end else if (i_wd_reset && rst_cnt_q != 4'hF) begin
            rst_cnt_d = rst_cnt_q + 4'h1;
        end
        multi_d = multi_q;
        if (i_rd.multi_reset) begin
            multi_d = 1'b0;
        end
        if (rst_cnt_q > 4'(flag_bank_pkg::MULTI_RESET_LIMIT)) begin
            multi_d = 1'b1;
        end
        wdf_d = wdf_q;
        if (i_rd.wd_fail) begin
            wdf_d = 1'b0;
        end
        if (i_wd_fail) begin
            wdf_d = 1'b1;
        end
        io1_off_d = i_io1_ov_off_en && (f_ov || f_aux);
    end

    always_ff @(posedge i_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            rst_cnt_q <= flag_bank_pkg::RESET_CNT_INIT;
            multi_q <= 1'b0;
            wdf_q <= 1'b0;
            io1_off_q <= 1'b0;
        end else begin
            rst_cnt_q <= rst_cnt_d;
            multi_q <= multi_d;
            wdf_q <= wdf_d;
            io1_off_q <= io1_off_d;
        end
    end

    // ------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------
    flag_bank_pkg::flags_t flags_q;
    flag_bank_pkg::flags_t flags_d;
    logic vdd5_q;
    logic [1:0] fam_q;
    logic [4:0] rev_q;

    always_comb begin
        flags_d = {f_int, f_rsth, f_dbg, f_temp, f_uv, f_ov, f_aux, f_uvl,
                   f_low, f_rstl, multi_q, wdf_q, 1'b0};
    end

    always_ff @(posedge i_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            flags_q <= flag_bank_pkg::FLAGS_INIT;
            vdd5_q <= 1'b0;
            fam_q <= 2'h0;
            rev_q <= 5'h00;
        end else begin
            flags_q <= flags_d;
            vdd5_q <= VARIANT_5V;
            fam_q <= FAMILY_CODE;
            rev_q <= REVISION_CODE;
        end
    end

    assign o_flags = flags_q;
    assign o_vdd_5v = vdd5_q;
    assign o_family = fam_q;
    assign o_revision = rev_q;
    assign o_io1_off = io1_off_q;

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    a_wd_fail_set: assert property (
        @(posedge i_clk) disable iff (!i_arst_n)
        i_wd_fail |=> ##1 o_flags.wd_fail)
        else $error("watchdog failure flag not set");
    a_wd_fail_clr: assert property (
        @(posedge i_clk) disable iff (!i_arst_n)
        (i_rd.wd_fail && !i_wd_fail) |=> ##1 !o_flags.wd_fail)
        else $error("watchdog failure flag not cleared");
    a_multi_set: assert property (
        @(posedge i_clk) disable iff (!i_arst_n)
        (rst_cnt_q > 4'h8) |=> ##1 o_flags.multi_reset)
        else $error("multiple reset flag missing");
    a_multi_quiet: assert property (
        @(posedge i_clk) disable iff (!i_arst_n)
        (rst_cnt_q <= 4'h8 && $past(rst_cnt_q) <= 4'h8 && i_rd.multi_reset)
        |=> ##1 !o_flags.multi_reset)
        else $error("multiple reset flag set too early");
    a_io1_off: assert property (
        @(posedge i_clk) disable iff (!i_arst_n)
        (i_io1_ov_off_en && f_ov) |=> o_io1_off)
        else $error("io1 not switched off on overvoltage");
    a_io1_keep: assert property (
        @(posedge i_clk) disable iff (!i_arst_n)
        !i_io1_ov_off_en |=> !o_io1_off)
        else $error("io1 switched off while not enabled");
    a_int_flag: assert property (
        @(posedge i_clk) disable iff (!i_arst_n)
        i_int_req |=> ##1 o_flags.int_request)
        else $error("interrupt request flag not set");
    a_uv_hold: assert property (
        @(posedge i_clk) disable iff (!i_arst_n)
        (f_uv && cond.main_uv) |=> f_uv)
        else $error("undervoltage flag dropped while low");
    a_low_clr: assert property (
        @(posedge i_clk) disable iff (!i_arst_n)
        (f_low && i_rd.main_low && !cond.main_uv) |=> !f_low)
        else $error("main low flag not cleared by read");
    a_static_ids: assert property (
        @(posedge i_clk) disable iff (!i_arst_n)
        $past(i_arst_n) |-> (o_revision == REVISION_CODE
        && o_family == FAMILY_CODE && o_vdd_5v == VARIANT_5V))
        else $error("static identity fields wrong");
endmodule

/* File: bench/flag_reader.sv */
/*
 Holds a model of the controller that reads the flag bank and pulses
 the clearing strobes set in its mask per read. Assumes a free-running i_clk.
*/
`timescale 1ns/1ps
module flag_reader (
    input wire logic i_clk, // core clock
    output flag_bank_pkg::rd_t o_rd // clearing read strobes
);
    initial o_rd = '0;

    // one read frame: strobes stand for exactly one clock
    task automatic read(input flag_bank_pkg::rd_t m);
        @(negedge i_clk);
        o_rd = m;
        @(negedge i_clk);
        o_rd = '0;
    endtask
endmodule

/* File: bench/supply_reset_flag_bank_test.sv */
/*
 Holds the self-checking bench of the supply and reset flag bank.
 Assumes short filters of 8 and 40 cycles and a 50 MHz clock.
*/
`timescale 1ns/1ps
`define CHK(nm, e, g) begin n_tests++; if ((g) !== (e)) begin fails++; \
    $display("CHECK FAILED %s exp %0h got %0h", nm, e, g); end end
module supply_reset_flag_bank_test;
    logic clk = 1'b0;
    logic arst_n = 1'b0;
    logic [3:0] ev = 4'h0; // int_req, wd_fail, wd_reset, wd_good
    logic io1_en = 1'b0;
    flag_bank_pkg::cond_t cause = '0;
    flag_bank_pkg::rd_t rd_s;
    flag_bank_pkg::flags_t flags;
    logic vdd_5v;
    logic [1:0] family;
    logic [4:0] revision;
    logic io1_off;
    int fails = 0;
    int n_tests = 0;
    int cyc = 0;

    initial forever #10 clk = ~clk;

    supply_reset_flag_bank #(.SHORT_CYC(8), .LONG_CYC(40),
        .VARIANT_5V(1'b0),
        .REVISION_CODE(5'h0A)) supply_reset_flag_bank_inst ( // arbitrary
        .i_clk(clk), .i_arst_n(arst_n), .i_int_req(ev[3]),
        .i_rst_high_fault(cause.rst_high),
        .i_dbg_sensed_ok(~cause.dbg_mismatch),
        .i_temp_over(cause.temp_prewarn), .i_main_below_uv(cause.main_uv),
        .i_main_above_ov(cause.main_ov), .i_aux_above_ov(cause.aux_ov),
        .i_rst_pin_low(cause.rst_low), .i_wd_reset(ev[1]),
        .i_wd_good(ev[0]), .i_wd_fail(ev[2]), .i_io1_ov_off_en(io1_en),
        .i_rd(rd_s), .o_flags(flags), .o_vdd_5v(vdd_5v),
        .o_family(family), .o_revision(revision), .o_io1_off(io1_off));

    flag_reader flag_reader_inst (.i_clk(clk), .o_rd(rd_s));

    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    task automatic wt(input int n);
        repeat (n) @(negedge clk);
    endtask

    task automatic rd(input int fi);
        flag_bank_pkg::rd_t m;
        m = '0;
        m[fi-1] = 1'b1;
        flag_reader_inst.read(m);
    endtask

    task automatic pev(input int k);
        @(negedge clk);
        ev[k] = 1'b1;
        @(negedge clk);
        ev[k] = 1'b0;
    endtask

    // event flag: set by pulse, cleared by read alone
    task automatic pulse_flag(input int k, input int fi);
        pev(k);
        wt(3);
        `CHK("event flag set", 1'b1, flags[fi])
        rd(fi);
        wt(3);
        `CHK("event flag clear", 1'b0, flags[fi])
    endtask

    // level flag: rises under cause, read refused while cause holds when nr is set
    task automatic recov(input int ci, input int fi, input bit nr,
                         input int lim);
        cause[ci] = 1'b1;
        for (int i = 0; i < lim && flags[fi] !== 1'b1; i++) wt(1);
        `CHK("level flag set", 1'b1, flags[fi])
        if (nr) begin
            rd(fi);
            wt(4);
            `CHK("read under cause", 1'b1, flags[fi])
        end
        cause[ci] = 1'b0;
        wt(8);
        `CHK("flag kept after recovery", 1'b1, flags[fi])
        rd(fi);
        wt(3);
        `CHK("flag cleared", 1'b0, flags[fi])
    endtask

    task automatic conclude();
        $display("comparisons %0d mismatches %0d", n_tests, fails);
        if (fails == 0 && n_tests > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask

    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            fails++;
            conclude();
        end
    end

    // ------------------------------------------------------------
    // tests
    // ------------------------------------------------------------
    initial begin
        repeat (6) @(posedge clk);
        @(negedge clk);
        arst_n = 1'b1;
        wt(2);
        `CHK("flags after reset", 13'h0000, flags)
        `CHK("variant bit", 1'b0, vdd_5v)
        `CHK("family code", 2'h3, family)
        `CHK("revision code", 5'h0A, revision)
        pulse_flag(3, 12);
        pulse_flag(2, 1);
        pev(2);
        wt(3);
        @(negedge clk);
        ev[2] = 1'b1;
        flag_reader_inst.read(12'h001);
        ev[2] = 1'b0;
        wt(4);
        `CHK("set beats read", 1'b1, flags.wd_fail)
        rd(1);
        cause.main_ov = 1'b1;
        wt(4);
        cause.main_ov = 1'b0;
        wt(15);
        `CHK("short glitch filtered", 1'b0, flags.main_ov)
        recov(6, 11, 1'b0, 15);
        recov(5, 10, 1'b1, 15);
        recov(4, 9, 1'b1, 15);
        recov(3, 8, 1'b1, 25);
        recov(2, 7, 1'b1, 25);
        recov(1, 6, 1'b1, 25);
        recov(3, 5, 1'b1, 60);
        recov(0, 3, 1'b1, 60);
        cause.main_uv = 1'b1;
        wt(8);
        `CHK("low flag set", 1'b1, flags.main_low)
        rd(4);
        wt(3);
        `CHK("low flag reset by cause", 1'b1, flags.main_low)
        cause.main_uv = 1'b0;
        wt(8);
        rd(4);
        wt(3);
        `CHK("low flag cleared", 1'b0, flags.main_low)
        cause.aux_ov = 1'b1;
        wt(20);
        io1_en = 1'b1;
        wt(3);
        `CHK("io1 dropped", 1'b1, io1_off)
        io1_en = 1'b0;
        wt(3);
        `CHK("io1 kept", 1'b0, io1_off)
        cause.aux_ov = 1'b0;
        cause.main_ov = 1'b1;
        wt(8);
        rd(6);
        wt(14);
        `CHK("aux flag gone", 1'b0, flags.aux_ov)
        io1_en = 1'b1;
        wt(3);
        `CHK("io1 dropped main", 1'b1, io1_off)
        io1_en = 1'b0;
        cause.main_ov = 1'b0;
        wt(8);
        flag_reader_inst.read('1);
        wt(3);
        `CHK("all cleared", 13'h0000, flags)
        repeat (8) pev(1);
        wt(4);
        `CHK("eight resets", 1'b0, flags.multi_reset)
        pev(1);
        wt(4);
        `CHK("ninth reset", 1'b1, flags.multi_reset)
        pev(0);
        rd(2);
        wt(3);
        `CHK("multi cleared", 1'b0, flags.multi_reset)
        repeat (8) pev(1);
        pev(0);
        pev(1);
        wt(4);
        `CHK("count zeroed by refresh", 1'b0, flags.multi_reset)
        conclude();
    end
endmodule
